// ==== hdl/rxcmd_params.svh ====
// Constants for the receive-command status encoder
`ifndef RXCMD_PARAMS_SVH
`define RXCMD_PARAMS_SVH
`define LS_LSB        0
`define VB_LSB        2
`define EV_LSB        4
`define RSV_BIT       6
`define ALT_BIT       7
`define XCVR_HS       2'h0
`define XCVR_FS       2'h1
`define XCVR_LS       2'h2
`define XCVR_FS4LS    2'h3
`define OPMODE_CHIRP  2'h2
`define EV_IDLE       2'h0
`define EV_ACTIVE     2'h1
`define EV_ERROR      2'h3
`define EV_DISCON     2'h2
`define VB_BELOW_END  2'h0
`define VB_END        2'h1
`define VB_SESS       2'h2
`define VB_AVALID     2'h3
`define REG_CTRL      32'h0000_0000
`define REG_STATUS    32'h0000_0004
`define REG_LAST      32'h0000_0008
`define CTRL_RST      32'h0000_0000
`endif

// ==== hdl/rxcmd_pkg.sv ====
// Types for the receive-command status encoder
package rxcmd_pkg;
    typedef struct packed {
        logic       alt;
        logic       rsv;
        logic [1:0] event_code;
        logic [1:0] vbus;
        logic [1:0] line;
    } status_byte_t;

    typedef struct packed {
        logic       bvalid_rise_en;
        logic       bvalid_fall_en;
        logic       use_fault;
        logic       fault_invert;
        logic       low_power;
        logic       host_mode;
        logic       opmode_chirp;
        logic       termselect;
        logic [1:0] xcvrselect;
    } config_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_TURN
    } link_state_t;
endpackage : rxcmd_pkg

// ==== hdl/ulpi_rxcmd_status_encoder.sv ====
// RXCMD status encoder with Wishbone control registers and ULPI-clock link side
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "rxcmd_params.svh"

module ulpi_rxcmd_status_encoder (
    input  wire logic        clk_i,          // Bus clock, 250 MHz
    input  wire logic        rst_i,          // Synchronous reset, high
    input  wire logic        wb_cyc_i,       // Wishbone cycle
    input  wire logic        wb_stb_i,       // Wishbone strobe
    input  wire logic        wb_we_i,        // Wishbone write
    input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects
    input  wire logic [31:0] wb_adr_i,       // Wishbone byte address
    input  wire logic [31:0] wb_dat_i,       // Wishbone write data
    output logic      [31:0] wb_dat_o,       // Wishbone read data
    output logic             wb_ack_o,       // Wishbone acknowledge
    input  wire logic        ulpi_clk_i,     // ULPI 60 MHz clock
    input  wire logic        ulpi_rst_i,     // ULPI-domain reset, high
    input  wire logic        dp_i,           // Single-ended plus line
    input  wire logic        dm_i,           // Single-ended minus line
    input  wire logic        squelch_i,      // High-speed squelch active
    input  wire logic        hs_diff_i,      // High-speed differential receiver
    input  wire logic        session_end_indicator_i,     // Session-end comparator
    input  wire logic        session_valid_indicator_i,     // Session-valid comparator
    input  wire logic        a_device_vbus_valid_i,   // A-device VBUS valid comparator
    input  wire logic        fault_i,        // External fault on shared pin
    input  wire logic        bvalid_i,       // B-session valid comparator
    input  wire logic        rx_active_i,    // Receive active
    input  wire logic        rx_error_i,     // Receive error
    input  wire logic        host_discon_i,  // Host disconnect
    output logic             ulpi_dir_o,     // ULPI direction
    output logic      [7:0]  ulpi_data_o,    // ULPI data out
    output logic      [7:0]  ulpi_data_oe_n_o // ULPI data enable, low drives
);

    rxcmd_pkg::config_t      cfg_q;
    rxcmd_pkg::status_byte_t last_q;
    logic [31:0] rdata_d;
    logic        wb_req;
    logic        wb_wr;
    logic        cfg_tgl_q;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Write lands on the edge after the one that presents the acknowledge
    assign wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

    // Wishbone slave: one-cycle ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= rxcmd_pkg::config_t'(10'(`CTRL_RST));
        end else if (wb_wr && wb_adr_i == `REG_CTRL) begin
            if (wb_sel_i[0]) cfg_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) cfg_q[9:8] <= wb_dat_i[9:8];
        end
    end

    // Each control write flips this flag for the link side
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_tgl_q <= 1'b0;
        end else if (wb_wr && wb_adr_i == `REG_CTRL) begin
            cfg_tgl_q <= ~cfg_tgl_q;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (wb_adr_i)
            `REG_CTRL:   rdata_d = {22'h000000, cfg_q};
            `REG_LAST:   rdata_d = {24'h000000, last_q};
            default:     rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req) begin
            wb_dat_o <= rdata_d;
        end
    end

    // Configuration into ULPI domain: flag synchronised, then stable word taken
    // Writes closer than three link clocks apart may be taken torn
    logic [2:0]         cfg_tgl_s;
    rxcmd_pkg::config_t cfg_u_q;
    always_ff @(posedge ulpi_clk_i) begin
        if (ulpi_rst_i) begin
            cfg_tgl_s <= 3'h0;
        end else begin
            cfg_tgl_s <= {cfg_tgl_s[1:0], cfg_tgl_q};
        end
    end
    always_ff @(posedge ulpi_clk_i) begin
        if (ulpi_rst_i) begin
            cfg_u_q <= rxcmd_pkg::config_t'(10'(`CTRL_RST));
        end else if (cfg_tgl_s[2] != cfg_tgl_s[1]) begin
            cfg_u_q <= cfg_q;
        end
    end
    rxcmd_pkg::config_t cfg_u;
    assign cfg_u = cfg_u_q;

    // Analog inputs synchronised into the ULPI domain
    logic [10:0] in_s1;
    logic [10:0] in_s2;
    always_ff @(posedge ulpi_clk_i) begin
        if (ulpi_rst_i) begin
            in_s1 <= 11'h000;
            in_s2 <= 11'h000;
        end else begin
            in_s1 <= {dp_i, dm_i, squelch_i, hs_diff_i, session_end_indicator_i, session_valid_indicator_i,
                      a_device_vbus_valid_i, fault_i, bvalid_i, rx_active_i, rx_error_i};
            in_s2 <= in_s1;
        end
    end
    logic dp_s, dm_s, sq_s, hsd_s, se_s, sv_s, av_s, flt_s, bv_s, ra_s, re_s;
    assign {dp_s, dm_s, sq_s, hsd_s, se_s, sv_s, av_s, flt_s, bv_s, ra_s, re_s} = in_s2;

    logic [1:0] dis_s;
    always_ff @(posedge ulpi_clk_i) begin
        if (ulpi_rst_i) begin
            dis_s <= 2'h0;
        end else begin
            dis_s <= {dis_s[0], host_discon_i};
        end
    end

    // Line state by speed, termination, mode and role
    logic [1:0] line_d;
    logic [1:0] fs_line;
    logic [1:0] hs_line;
    assign fs_line = {dm_s, dp_s};
    assign hs_line = sq_s ? 2'h0 : 2'h1;
    always_comb begin
        line_d = fs_line;
        case (cfg_u.xcvrselect)
            `XCVR_LS: begin
                // Low-speed K is plus line high: same pin order as full speed
                line_d = fs_line;
            end
            `XCVR_HS: begin
                if ((cfg_u.host_mode && cfg_u.opmode_chirp && !cfg_u.termselect) ||
                    (!cfg_u.host_mode && cfg_u.termselect)) begin
                    line_d = sq_s ? 2'h0 : (hsd_s ? 2'h1 : 2'h2);
                end else begin
                    line_d = hs_line;
                end
            end
            default: line_d = fs_line;
        endcase
    end

    // VBUS state from comparators; fault optionally replaces A-valid
    logic       avalid;
    logic [1:0] vbus_d;
    assign avalid = cfg_u.use_fault ? (flt_s ^ cfg_u.fault_invert) : av_s;
    always_comb begin
        if (avalid)       vbus_d = `VB_AVALID;
        else if (sv_s)    vbus_d = `VB_SESS;
        else if (se_s)    vbus_d = `VB_BELOW_END;
        else              vbus_d = `VB_END;
    end

    logic [1:0] ev_d;
    always_comb begin
        if (dis_s[1] && cfg_u.host_mode) ev_d = `EV_DISCON;
        else if (ra_s && re_s)           ev_d = `EV_ERROR;
        else if (ra_s)                   ev_d = `EV_ACTIVE;
        else                             ev_d = `EV_IDLE;
    end

    // B-valid edges flag the alternate interrupt bit
    logic bv_q;
    logic alt_evt;
    logic alt_hold_q;
    always_ff @(posedge ulpi_clk_i) begin
        if (ulpi_rst_i) bv_q <= 1'b0;
        else            bv_q <= bv_s;
    end
    assign alt_evt = (bv_s & ~bv_q & cfg_u.bvalid_rise_en) |
                     (~bv_s & bv_q & cfg_u.bvalid_fall_en);

    rxcmd_pkg::status_byte_t cur;
    assign cur = '{alt: alt_evt | alt_hold_q, rsv: 1'b0,
                   event_code: ev_d, vbus: vbus_d, line: line_d};

    // Sender: pending change latched and kept if restored until the send state; low power suppresses and clears it
    rxcmd_pkg::status_byte_t sent_q;
    rxcmd_pkg::link_state_t  st_q;
    logic                    pend_q;
    logic                    changed;
    logic                    load_byte;
    assign changed = ({cur.event_code, cur.vbus, cur.line} !=
                      {sent_q.event_code, sent_q.vbus, sent_q.line}) | cur.alt;
    assign load_byte = (st_q == rxcmd_pkg::ST_TURN) ||
                       (st_q == rxcmd_pkg::ST_SEND && changed && !cfg_u.low_power);

    // B-valid edge held until a byte carries it or low power clears it; the edge wins over the clear
    always_ff @(posedge ulpi_clk_i) begin
        if (ulpi_rst_i) begin
            alt_hold_q <= 1'b0;
        end else if (alt_evt) begin
            alt_hold_q <= 1'b1;
        end else if (load_byte || cfg_u.low_power) begin
            alt_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge ulpi_clk_i) begin
        if (ulpi_rst_i) begin
            pend_q <= 1'b0;
        end else if (cfg_u.low_power) begin
            pend_q <= 1'b0;
        end else if (changed) begin
            pend_q <= 1'b1;
        end else if (st_q == rxcmd_pkg::ST_SEND) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge ulpi_clk_i) begin
        if (ulpi_rst_i) begin
            st_q        <= rxcmd_pkg::ST_IDLE;
            sent_q      <= '0;
            ulpi_dir_o  <= 1'b0;
            ulpi_data_o <= 8'h00;
        end else begin
            case (st_q)
                rxcmd_pkg::ST_IDLE: begin
                    if ((pend_q || changed) && !cfg_u.low_power) begin
                        ulpi_dir_o <= 1'b1;
                        st_q       <= rxcmd_pkg::ST_TURN;
                    end
                    ulpi_data_o <= 8'h00;
                end
                rxcmd_pkg::ST_TURN: begin
                    ulpi_data_o <= cur;
                    sent_q      <= cur;
                    st_q        <= rxcmd_pkg::ST_SEND;
                end
                rxcmd_pkg::ST_SEND: begin
                    if (changed && !cfg_u.low_power) begin
                        ulpi_data_o <= cur;
                        sent_q      <= cur;
                    end else begin
                        ulpi_dir_o  <= 1'b0;
                        ulpi_data_o <= 8'h00;
                        st_q        <= rxcmd_pkg::ST_IDLE;
                    end
                end
                default: st_q <= rxcmd_pkg::ST_IDLE;
            endcase
        end
    end

    assign ulpi_data_oe_n_o = (st_q == rxcmd_pkg::ST_SEND) ? 8'h00 : 8'hFF;

    // Last byte into bus domain via toggle handshake
    logic       tgl_q;
    rxcmd_pkg::status_byte_t hold_q;
    always_ff @(posedge ulpi_clk_i) begin
        if (ulpi_rst_i) begin
            tgl_q  <= 1'b0;
            hold_q <= '0;
        end else if (load_byte) begin
            tgl_q  <= ~tgl_q;
            hold_q <= cur;
        end
    end
    logic [2:0] tgl_s;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tgl_s  <= 3'h0;
            last_q <= '0;
        end else begin
            tgl_s <= {tgl_s[1:0], tgl_q};
            if (tgl_s[2] != tgl_s[1]) last_q <= hold_q;
        end
    end

    // Byte cycle on the data lines with the alternate flag set
    sequence s_alt_byte;
        !ulpi_data_oe_n_o[0] && ulpi_data_o[`ALT_BIT];
    endsequence

    a_reserved_zero: assert property (@(posedge ulpi_clk_i) disable iff (ulpi_rst_i)
        ulpi_dir_o |-> !ulpi_data_o[`RSV_BIT]) else $error("reserved bit set");
    a_change_sends: assert property (@(posedge ulpi_clk_i) disable iff (ulpi_rst_i)
        (changed && !cfg_u.low_power && st_q == rxcmd_pkg::ST_IDLE) |=> ulpi_dir_o)
        else $error("change without send");
    a_turn_then_byte: assert property (@(posedge ulpi_clk_i) disable iff (ulpi_rst_i)
        $rose(ulpi_dir_o) |=> ulpi_dir_o && !ulpi_data_oe_n_o[0]) else $error("no byte after turn");
    a_lowpower_quiet: assert property (@(posedge ulpi_clk_i) disable iff (ulpi_rst_i)
        (cfg_u.low_power && st_q == rxcmd_pkg::ST_IDLE) |=> !ulpi_dir_o) else $error("send in low power");
    a_alt_sent: assert property (@(posedge ulpi_clk_i) disable iff (ulpi_rst_i)
        (alt_evt && !cfg_u.low_power) |-> ##[1:2] s_alt_byte) else $error("alternate flag not sent");
    a_bus_released: assert property (@(posedge ulpi_clk_i) disable iff (ulpi_rst_i)
        !ulpi_dir_o |-> (ulpi_data_oe_n_o == 8'hFF) && (ulpi_data_o == 8'h00))
        else $error("data driven without direction");
    a_wb_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held");

endmodule : ulpi_rxcmd_status_encoder

`default_nettype wire

// ==== tb/link_model.sv ====
// Link-side receiver model that collects status bytes
`timescale 1ns/1ns
`default_nettype none
module link_model (
    input  wire logic       ulpi_clk_i, // Link clock
    input  wire logic       rst_i,      // Link-side reset, high
    input  wire logic       dir_i,      // Direction from device
    input  wire logic [7:0] data_i,     // Status byte lines
    input  wire logic [7:0] oe_n_i      // Data enable, low drives
);
    logic [7:0] last_q  = 8'h00;
    int         count_q = 0;
    int         alt_q   = 0;
    int         bad_q   = 0;

    // Takes a byte on any cycle the device drives, single or back to back
    always @(posedge ulpi_clk_i) begin
        if (dir_i === 1'b1 && oe_n_i === 8'h00) begin
            last_q <= data_i;
            count_q <= count_q + 1;
            if (data_i[7] === 1'b1) begin
                alt_q <= alt_q + 1;
            end
        end
        if (!rst_i && dir_i !== 1'b1 && oe_n_i !== 8'hFF) begin
            bad_q <= bad_q + 1;
        end
    end
endmodule // link_model
`default_nettype wire

// ==== tb/tb_ulpi_rxcmd_status_encoder.sv ====
// Testbench for the receive-command status encoder
`timescale 1ns/1ns
`default_nettype none
module tb_ulpi_rxcmd_status_encoder;
    logic        clk  = 1'b0;
    logic        uclk = 1'b0;
    logic        rst  = 1'b1;
    logic        urst = 1'b1;
    logic        cyc  = 1'b0;
    logic        stb  = 1'b0;
    logic        we   = 1'b0;
    logic [31:0] adr  = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic        ack;
    logic [11:0] ins  = 12'h280;
    logic        dir;
    logic [7:0]  data;
    logic [7:0]  oe_n;
    int          n_errors   = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    int          n_sent     = 0;

    always #2 clk = ~clk;
    always begin
        #62 uclk = 1'b1;
        #63 uclk = 1'b0;
    end

    ulpi_rxcmd_status_encoder i_dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ulpi_clk_i(uclk), .ulpi_rst_i(urst), .dp_i(ins[11]), .dm_i(ins[10]),
        .squelch_i(ins[9]), .hs_diff_i(ins[8]), .session_end_indicator_i(ins[7]), .session_valid_indicator_i(ins[6]),
        .a_device_vbus_valid_i(ins[5]), .fault_i(ins[4]), .bvalid_i(ins[3]), .rx_active_i(ins[2]),
        .rx_error_i(ins[1]), .host_discon_i(ins[0]), .ulpi_dir_o(dir), .ulpi_data_o(data),
        .ulpi_data_oe_n_o(oe_n)
    );
    link_model i_link (.ulpi_clk_i(uclk), .rst_i(urst), .dir_i(dir), .data_i(data), .oe_n_i(oe_n));

    task automatic results;
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits for the acknowledge; only the bench timeout ends a hang
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Config, pin levels, field mask, expected byte, expected flagged-byte count
    task automatic r(input logic [9:0] c, input logic [11:0] v, input logic [7:0] m,
                     input logic [7:0] e, input int a);
        wb(1'b1, 32'h0, {22'h0, c});
        repeat (4) @(posedge uclk);
        @(posedge clk);
        ins <= v;
        repeat (16) @(posedge uclk);
        check("byte", {24'h0, i_link.last_q & m}, {24'h0, e});
        check("alt", i_link.alt_q, a);
        wb(1'b0, 32'h8, 32'h0);
        check("last", rd, {24'h0, i_link.last_q});
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge uclk);
        urst <= 1'b0;
        repeat (4) @(posedge uclk);
        wb(1'b0, 32'h0, 32'h0);
        check("ctrl", rd, 32'h0);
        wb(1'b1, 32'h10, 32'hFFFF_FFFF);
        wb(1'b0, 32'h10, 32'h0);
        check("unmapped", rd, 32'h0);
        wb(1'b0, 32'h4, 32'h0);
        check("status", rd, 32'h0);
        wb(1'b1, 32'h0, 32'h0000_03FF);
        wb(1'b0, 32'h0, 32'h0);
        check("ctrl", rd, 32'h0000_03FF);
        r(10'h005, 12'h800, 8'h43, 8'h01, 0);
        r(10'h005, 12'h400, 8'h43, 8'h02, 0);
        r(10'h005, 12'h000, 8'h43, 8'h00, 0);
        r(10'h005, 12'hC00, 8'h43, 8'h03, 0);
        r(10'h007, 12'h800, 8'h43, 8'h01, 0);
        r(10'h000, 12'h200, 8'h43, 8'h00, 0);
        r(10'h000, 12'h000, 8'h43, 8'h01, 0);
        r(10'h004, 12'h100, 8'h43, 8'h01, 0);
        r(10'h004, 12'h000, 8'h43, 8'h02, 0);
        r(10'h004, 12'h200, 8'h43, 8'h00, 0);
        r(10'h016, 12'h800, 8'h43, 8'h01, 0);
        r(10'h016, 12'h400, 8'h43, 8'h02, 0);
        r(10'h015, 12'h800, 8'h43, 8'h01, 0);
        r(10'h010, 12'h000, 8'h43, 8'h01, 0);
        r(10'h018, 12'h100, 8'h43, 8'h01, 0);
        r(10'h018, 12'h000, 8'h43, 8'h02, 0);
        r(10'h005, 12'h080, 8'h4C, 8'h00, 0);
        r(10'h005, 12'h000, 8'h4C, 8'h04, 0);
        r(10'h005, 12'h040, 8'h4C, 8'h08, 0);
        r(10'h005, 12'h0C0, 8'h4C, 8'h08, 0);
        r(10'h005, 12'h020, 8'h4C, 8'h0C, 0);
        r(10'h085, 12'h010, 8'h4C, 8'h0C, 0);
        r(10'h085, 12'h020, 8'h4C, 8'h04, 0);
        r(10'h0C5, 12'h000, 8'h4C, 8'h0C, 0);
        r(10'h005, 12'h004, 8'h70, 8'h10, 0);
        r(10'h005, 12'h006, 8'h70, 8'h30, 0);
        r(10'h015, 12'h001, 8'h70, 8'h20, 0);
        r(10'h015, 12'h007, 8'h70, 8'h20, 0);
        r(10'h005, 12'h001, 8'h70, 8'h00, 0);
        r(10'h005, 12'h000, 8'h70, 8'h00, 0);
        r(10'h005, 12'h288, 8'h00, 8'h00, 0);
        r(10'h005, 12'h280, 8'h00, 8'h00, 0);
        r(10'h205, 12'h288, 8'h00, 8'h00, 1);
        r(10'h105, 12'h280, 8'h00, 8'h00, 2);
        r(10'h105, 12'h288, 8'h00, 8'h00, 2);
        r(10'h005, 12'h280, 8'h43, 8'h00, 2);
        n_sent = i_link.count_q;
        r(10'h025, 12'hA80, 8'h43, 8'h00, 2);
        check("quiet", i_link.count_q, n_sent);
        check("driven", i_link.bad_q, 32'h0);
        results();
    end
endmodule // tb_ulpi_rxcmd_status_encoder
`default_nettype wire
